// ---- inc/hsc_pkg.sv ----
package hsc_pkg;

	// Port and strap geometry
	localparam int NUM_PORTS = 6;
	localparam int CODE_W = 3;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SYNC_W = 3;

	// Resistor encodings of the multi-level straps, as delivered by the sensing front end
	localparam logic [2:0] CODE_200K_DN = 3'h0;
	localparam logic [2:0] CODE_200K_UP = 3'h1;
	localparam logic [2:0] CODE_10K_DN = 3'h2;
	localparam logic [2:0] CODE_10K_UP = 3'h3;
	localparam logic [2:0] CODE_10R_DN = 3'h4;
	localparam logic [2:0] CODE_10R_UP = 3'h5;

	// Port masks selected by the six encodings
	localparam logic [5:0] MASK_NONE = 6'h00;
	localparam logic [5:0] MASK_P1 = 6'h01;
	localparam logic [5:0] MASK_P12 = 6'h03;
	localparam logic [5:0] MASK_P123 = 6'h07;
	localparam logic [5:0] MASK_P1234 = 6'h0F;
	localparam logic [5:0] MASK_ALL = 6'h3F;

	// Register offsets
	localparam logic [7:0] REG_ROLE = 8'h00;
	localparam logic [7:0] REG_PORT_DIS = 8'h01;
	localparam logic [7:0] REG_FIXED = 8'h02;
	localparam logic [7:0] REG_CHARGE = 8'h03;
	localparam logic [7:0] REG_STAGE = 8'h04;
	localparam logic [7:0] REG_GPIO_DIR = 8'h10;
	localparam logic [7:0] REG_GPIO_OUT = 8'h11;
	localparam logic [7:0] REG_GPIO_PULL_EN = 8'h12;
	localparam logic [7:0] REG_GPIO_PULL_UP = 8'h13;
	localparam logic [7:0] REG_GPIO_IN = 8'h14;
	localparam logic [7:0] REG_CFG_DONE = 8'hFF;

	// Role register field positions
	localparam int ROLE_MASTER_BIT = 0;
	localparam int ROLE_SLAVE_BIT = 1;
	localparam int ROLE_MODE_LSB = 4;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Boot stages
	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_STRAP = 3'h1,
		ST_EXT_CFG = 3'h2,
		ST_OTP_CFG = 3'h3,
		ST_RUN = 3'h4
	} hsc_stage_type;

	// Raw strap levels from the pads
	typedef struct packed {
		logic [5:0] dplus_dis;
		logic [5:0] dminus_dis;
		logic [2:0] mode_code;
		logic [2:0] fixed_code;
		logic [2:0] charge_code;
		logic smbclk_pullup;
		logic smbdata_pullup;
	} hsc_strap_type;

	// One write from the feature-controller bridge
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} hsc_bridge_wr_type;

endpackage

// ---- rtl/hsc_strap_decode.sv ----
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module hsc_strap_decode #(
	parameter int GPIO_W = 8,
	parameter int FIXED_PULL_W = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Strap pads and general pin inputs
	input wire hsc_pkg::hsc_strap_type strap_pins,
	input wire logic [GPIO_W-1:0] general_io_pin_i,
	// Hub state from the USB core
	input wire logic enumerated,
	// SMBus slave register port
	input wire logic [hsc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [hsc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [hsc_pkg::DATA_W-1:0] reg_rdata,
	// Feature-controller bridge write port
	input wire hsc_pkg::hsc_bridge_wr_type bridge_wr,
	// Decoded settings
	output logic smbus_master_en,
	output logic smbus_slave_en,
	output logic [hsc_pkg::NUM_PORTS-1:0] port_dplus_disable_strap,
	output logic [hsc_pkg::NUM_PORTS-1:0] port_dminus_disable_strap,
	output logic [hsc_pkg::NUM_PORTS-1:0] legacy_port_disable,
	output logic [hsc_pkg::NUM_PORTS-1:0] ss_port_disable,
	output logic [hsc_pkg::NUM_PORTS-1:0] fixed_port_mask,
	output logic [hsc_pkg::NUM_PORTS-1:0] charging_port_mask,
	output logic [2:0] config_stage,
	// General pin drive and pull controls
	output logic [GPIO_W-1:0] general_io_pin_o,
	output logic [GPIO_W-1:0] general_io_pin_oe,
	output logic [GPIO_W-1:0] general_io_pull_up,
	output logic [GPIO_W-1:0] general_io_pull_dn,
	output logic [FIXED_PULL_W-1:0] fixed_pull_en
);

	localparam int STRAP_W = $bits(hsc_pkg::hsc_strap_type);
	localparam int IN_W = STRAP_W + GPIO_W;

	// Elaboration-time parameter checks
	if (GPIO_W < 1 || GPIO_W > hsc_pkg::DATA_W) begin : g_bad_gpio
		$error("GPIO_W must be 1 to DATA_W");
	end
	if (FIXED_PULL_W < 1) begin : g_bad_pull
		$error("FIXED_PULL_W must be at least 1");
	end
	if (hsc_pkg::NUM_PORTS > hsc_pkg::DATA_W) begin : g_bad_ports
		$error("NUM_PORTS must fit one register word");
	end

	// Boot stage and the filtered strap view
	hsc_pkg::hsc_stage_type stage_r;
	hsc_pkg::hsc_strap_type strap_f;
	// Pad synchroniser chain, straps above the general pins
	logic [IN_W-1:0] pad_in;
	logic [IN_W-1:0] sync1_r;
	logic [IN_W-1:0] sync2_r;
	logic [IN_W-1:0] sync3_r;
	logic [IN_W-1:0] filt_r;
	logic [GPIO_W-1:0] gpio_in_f;
	// Pin setup registers written over either path, and the registered input levels
	logic [GPIO_W-1:0] dir_r;
	logic [GPIO_W-1:0] out_r;
	logic [GPIO_W-1:0] pull_en_r;
	logic [GPIO_W-1:0] pull_up_sel_r;
	logic [GPIO_W-1:0] gpio_in_r;
	// Latched mode code and write qualifiers
	logic [2:0] mode_code_r;
	logic smb_wr_ok;
	logic br_wr_ok;
	logic capture;
	logic [hsc_pkg::NUM_PORTS-1:0] both_dis;

	// Maps a six-way resistor code to a low-ports mask; unknown codes give none
	// The low ports fill first; each step adds one more port, except the last, which adds ports five and six
	function automatic logic [5:0] code_mask(input logic [2:0] code);
		logic [5:0] m;
		m = hsc_pkg::MASK_NONE;
		case (code)
			hsc_pkg::CODE_200K_DN: m = hsc_pkg::MASK_NONE;
			hsc_pkg::CODE_200K_UP: m = hsc_pkg::MASK_P1;
			hsc_pkg::CODE_10K_DN: m = hsc_pkg::MASK_P12;
			hsc_pkg::CODE_10K_UP: m = hsc_pkg::MASK_P123;
			hsc_pkg::CODE_10R_DN: m = hsc_pkg::MASK_P1234;
			hsc_pkg::CODE_10R_UP: m = hsc_pkg::MASK_ALL;
			default: m = hsc_pkg::MASK_NONE;
		endcase
		return m;
	endfunction

	// Merges one register write into a pin vector
	// Bits above the pin count are dropped for narrow configurations
	function automatic logic [GPIO_W-1:0] wr_field(input logic [7:0] d);
		return d[GPIO_W-1:0];
	endfunction

	// One vector so a single loop covers every pad
	assign pad_in = {strap_pins, general_io_pin_i};

	// Three-stage synchroniser per pad bit; a level is taken once stages two and three agree.
	// No reset here, so the pads are tracked while rst is held and are ready at release.
	// The filter stage costs one more cycle, so a strap must be steady
	// for four edges before release to be taken cleanly.
	for (genvar i = 0; i < IN_W; i++) begin : g_sync
		always_ff @(posedge clock) begin
			sync1_r[i] <= pad_in[i];
			sync2_r[i] <= sync1_r[i];
			sync3_r[i] <= sync2_r[i];
			if (sync2_r[i] == sync3_r[i]) begin
				filt_r[i] <= sync3_r[i];
			end
		end
	end

	// Split the filtered vector back into straps and pin levels
	assign strap_f = filt_r[IN_W-1:GPIO_W];
	assign gpio_in_f = filt_r[GPIO_W-1:0];

	// Capture happens on the first edge after reset release
	// The reset stage lasts one cycle, so the straps are taken once per reset
	assign capture = (stage_r == hsc_pkg::ST_RESET);
	// A port drops only with both of its lines tied high
	assign both_dis = strap_f.dplus_dis & strap_f.dminus_dis;

	// Write qualification for the two configuration paths
	// Outside the external stage the SMBus path works only once enumerated
	assign smb_wr_ok = reg_wr && smbus_slave_en &&
		(enumerated || stage_r == hsc_pkg::ST_EXT_CFG);
	assign br_wr_ok = bridge_wr.wr && enumerated;

	// Boot stage sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			stage_r <= hsc_pkg::ST_RESET;
		end else begin
			case (stage_r)
				hsc_pkg::ST_RESET: begin
					// One cycle to take the straps
					stage_r <= hsc_pkg::ST_STRAP;
				end
				hsc_pkg::ST_STRAP: begin
					// Role is known now; the bus pull-ups pick the next stage
					if (smbus_slave_en && strap_f.smbclk_pullup && strap_f.smbdata_pullup) begin
						stage_r <= hsc_pkg::ST_EXT_CFG;
					end else begin
						stage_r <= hsc_pkg::ST_OTP_CFG;
					end
				end
				hsc_pkg::ST_EXT_CFG: begin
					// Waits with no time limit for the closing write
					if (smb_wr_ok && reg_addr == hsc_pkg::REG_CFG_DONE) begin
						stage_r <= hsc_pkg::ST_OTP_CFG;
					end
				end
				hsc_pkg::ST_OTP_CFG: begin
					// Stored and external settings merge here in one step
					stage_r <= hsc_pkg::ST_RUN;
				end
				hsc_pkg::ST_RUN: begin
					// Stays until the next reset
					stage_r <= hsc_pkg::ST_RUN;
				end
				default: begin
					// Illegal codes fall back to the reset stage
					stage_r <= hsc_pkg::ST_RESET;
				end
			endcase
		end
	end

	// Stage visible on a port
	// Lags the internal stage by one cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			config_stage <= hsc_pkg::ST_RESET;
		end else begin
			config_stage <= stage_r;
		end
	end

	// Device mode strap latch and SMBus role decode
	// Raw code kept for read-back in the role register
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_code_r <= hsc_pkg::CODE_200K_DN;
			smbus_master_en <= 1'b0;
			smbus_slave_en <= 1'b0;
		end else if (capture) begin
			mode_code_r <= strap_f.mode_code;
			smbus_master_en <= (strap_f.mode_code == hsc_pkg::CODE_200K_DN);
			smbus_slave_en <= (strap_f.mode_code == hsc_pkg::CODE_200K_UP);
			// Reserved codes leave both roles off
		end
	end

	// Port disable straps; held until the next reset
	// Fast ports follow the legacy pair, so no port is left half disabled
	always_ff @(posedge clock) begin
		if (rst) begin
			port_dplus_disable_strap <= hsc_pkg::MASK_NONE;
			port_dminus_disable_strap <= hsc_pkg::MASK_NONE;
			legacy_port_disable <= hsc_pkg::MASK_NONE;
			ss_port_disable <= hsc_pkg::MASK_NONE;
		end else if (capture) begin
			port_dplus_disable_strap <= strap_f.dplus_dis;
			port_dminus_disable_strap <= strap_f.dminus_dis;
			legacy_port_disable <= both_dis;
			ss_port_disable <= both_dis;
		end
	end

	// Non-removable and charging masks
	// Codes six and seven cannot come from a resistor and give no ports
	always_ff @(posedge clock) begin
		if (rst) begin
			fixed_port_mask <= hsc_pkg::MASK_NONE;
			charging_port_mask <= hsc_pkg::MASK_NONE;
		end else if (capture) begin
			fixed_port_mask <= code_mask(strap_f.fixed_code);
			charging_port_mask <= code_mask(strap_f.charge_code);
		end
	end

	// General pin setup registers; SMBus wins when both paths hit one register
	// Bridge writes come first, so a later SMBus assignment overrides them
	// Only the four setup offsets are writable; the rest drop silently
	always_ff @(posedge clock) begin
		if (rst) begin
			dir_r <= '0;
			out_r <= '0;
			pull_en_r <= '0;
			pull_up_sel_r <= '0;
		end else begin
			if (br_wr_ok) begin
				case (bridge_wr.addr)
					hsc_pkg::REG_GPIO_DIR: dir_r <= wr_field(bridge_wr.data);
					hsc_pkg::REG_GPIO_OUT: out_r <= wr_field(bridge_wr.data);
					hsc_pkg::REG_GPIO_PULL_EN: pull_en_r <= wr_field(bridge_wr.data);
					hsc_pkg::REG_GPIO_PULL_UP: pull_up_sel_r <= wr_field(bridge_wr.data);
					default: begin
					end
				endcase
			end
			if (smb_wr_ok) begin
				case (reg_addr)
					hsc_pkg::REG_GPIO_DIR: dir_r <= wr_field(reg_wdata);
					hsc_pkg::REG_GPIO_OUT: out_r <= wr_field(reg_wdata);
					hsc_pkg::REG_GPIO_PULL_EN: pull_en_r <= wr_field(reg_wdata);
					hsc_pkg::REG_GPIO_PULL_UP: pull_up_sel_r <= wr_field(reg_wdata);
					default: begin
					end
				endcase
			end
		end
	end

	// Pin drive: direction per pin, pulls only while the pin is an input
	// An input pin never drives, so a stale output value cannot leak out
	always_ff @(posedge clock) begin
		if (rst) begin
			general_io_pin_o <= '0;
			general_io_pin_oe <= '0;
			general_io_pull_up <= '0;
			general_io_pull_dn <= '0;
		end else begin
			general_io_pin_oe <= dir_r;
			general_io_pin_o <= out_r & dir_r;
			general_io_pull_up <= pull_en_r & pull_up_sel_r & ~dir_r;
			general_io_pull_dn <= pull_en_r & ~pull_up_sel_r & ~dir_r;
		end
	end

	// Pads with a built-in pull keep it on from reset onward
	// Software has no bit that turns these pulls off
	always_ff @(posedge clock) begin
		if (rst) begin
			fixed_pull_en <= '1;
		end else begin
			fixed_pull_en <= '1;
		end
	end

	// Filtered input levels of the general pins
	// Registered so the read mux sees a level that does not move mid-read
	always_ff @(posedge clock) begin
		if (rst) begin
			gpio_in_r <= '0;
		end else begin
			gpio_in_r <= gpio_in_f;
		end
	end

	// Read data stands for one cycle after the strobe, zero otherwise
	// Unused upper bits and unmapped offsets read as zero
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= hsc_pkg::RST_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				hsc_pkg::REG_ROLE: begin
					reg_rdata <= hsc_pkg::RST_ZERO;
					reg_rdata[hsc_pkg::ROLE_MASTER_BIT] <= smbus_master_en;
					reg_rdata[hsc_pkg::ROLE_SLAVE_BIT] <= smbus_slave_en;
					reg_rdata[hsc_pkg::ROLE_MODE_LSB +: hsc_pkg::CODE_W] <= mode_code_r;
				end
				hsc_pkg::REG_PORT_DIS: reg_rdata <= {2'h0, legacy_port_disable};
				hsc_pkg::REG_FIXED: reg_rdata <= {2'h0, fixed_port_mask};
				hsc_pkg::REG_CHARGE: reg_rdata <= {2'h0, charging_port_mask};
				hsc_pkg::REG_STAGE: reg_rdata <= {5'h00, stage_r};
				hsc_pkg::REG_GPIO_DIR: reg_rdata <= hsc_pkg::DATA_W'(dir_r);
				hsc_pkg::REG_GPIO_OUT: reg_rdata <= hsc_pkg::DATA_W'(out_r);
				hsc_pkg::REG_GPIO_PULL_EN: reg_rdata <= hsc_pkg::DATA_W'(pull_en_r);
				hsc_pkg::REG_GPIO_PULL_UP: reg_rdata <= hsc_pkg::DATA_W'(pull_up_sel_r);
				hsc_pkg::REG_GPIO_IN: reg_rdata <= hsc_pkg::DATA_W'(gpio_in_r);
				default: reg_rdata <= hsc_pkg::RST_ZERO;
			endcase
		end else begin
			reg_rdata <= hsc_pkg::RST_ZERO;
		end
	end

endmodule

// ---- tb/hsc_strap_decode_sva.sv ----
`timescale 1ns/1ps
module hsc_strap_decode_sva #(
	parameter int GPIO_W = 8,
	parameter int FIXED_PULL_W = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Decoded settings
	input wire logic smbus_master_en,
	input wire logic smbus_slave_en,
	input wire logic [5:0] port_dplus_disable_strap,
	input wire logic [5:0] port_dminus_disable_strap,
	input wire logic [5:0] legacy_port_disable,
	input wire logic [5:0] ss_port_disable,
	input wire logic [5:0] fixed_port_mask,
	input wire logic [2:0] config_stage,
	// Pin controls
	input wire logic [GPIO_W-1:0] general_io_pin_o,
	input wire logic [GPIO_W-1:0] general_io_pin_oe,
	input wire logic [GPIO_W-1:0] general_io_pull_up,
	input wire logic [GPIO_W-1:0] general_io_pull_dn,
	input wire logic [FIXED_PULL_W-1:0] fixed_pull_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic done_d_r;
	// Remembers a done write so the stage lag is not taken for a stall
	always_ff @(posedge clock) begin
		done_d_r <= reg_wr && (reg_addr == 8'hFF);
	end
	sequence done_write_s;
		(config_stage == 3'h2) && !done_d_r && reg_wr && (reg_addr == 8'hFF);
	endsequence
	sequence otp_then_run_s;
		(config_stage == 3'h3) ##1 (config_stage == 3'h4);
	endsequence
	chk_both_dis: assert property (legacy_port_disable ==
		(port_dplus_disable_strap & port_dminus_disable_strap)) else $error("Port disable mismatch");
	chk_ss_follow: assert property (ss_port_disable == legacy_port_disable)
		else $error("Fast port disable mismatch");
	chk_latch_hold: assert property (!$past(rst) && !$past(rst, 2) |->
		$stable(fixed_port_mask) && $stable(port_dplus_disable_strap) && $stable(smbus_slave_en))
		else $error("Latched strap changed");
	chk_role_excl: assert property (!(smbus_master_en && smbus_slave_en))
		else $error("Both bus roles on");
	chk_stage_done: assert property (done_write_s |=> ##1 otp_then_run_s)
		else $error("Done write did not end stage");
	chk_ext_wait: assert property ((config_stage == 3'h2) && !done_d_r &&
		!(reg_wr && reg_addr == 8'hFF) |=> config_stage == 3'h2) else $error("Stage left early");
	chk_ext_slave: assert property (config_stage == 3'h2 |-> smbus_slave_en)
		else $error("External stage without slave role");
	chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("Read data outside read slot");
	chk_out_input: assert property ((general_io_pin_o & ~general_io_pin_oe) == '0)
		else $error("Input pin drives");
	chk_pull_input: assert property (((general_io_pull_up | general_io_pull_dn)
		& general_io_pin_oe) == '0) else $error("Pull on output pin");
	chk_fixed_pull: assert property (&fixed_pull_en)
		else $error("Fixed pull dropped");
endmodule

bind hsc_strap_decode hsc_strap_decode_sva #(.GPIO_W(GPIO_W), .FIXED_PULL_W(FIXED_PULL_W)) u_sva (
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .smbus_master_en(smbus_master_en), .smbus_slave_en(smbus_slave_en),
	.port_dplus_disable_strap(port_dplus_disable_strap),
	.port_dminus_disable_strap(port_dminus_disable_strap),
	.legacy_port_disable(legacy_port_disable), .ss_port_disable(ss_port_disable),
	.fixed_port_mask(fixed_port_mask), .config_stage(config_stage),
	.general_io_pin_o(general_io_pin_o), .general_io_pin_oe(general_io_pin_oe),
	.general_io_pull_up(general_io_pull_up), .general_io_pull_dn(general_io_pull_dn),
	.fixed_pull_en(fixed_pull_en));

// ---- tb/hsc_board_model.sv ----
`timescale 1ns/1ps
module hsc_board_model (
	// Resistor codes and disable ties fitted on the board
	input wire logic [2:0] mode_code,
	input wire logic [2:0] fixed_code,
	input wire logic [2:0] charge_code,
	input wire logic [5:0] dis_p,
	input wire logic [5:0] dis_m,
	input wire logic [1:0] smb_pullups,
	// Levels seen at the strap pads
	output wire hsc_pkg::hsc_strap_type strap_pins
);
	// Fitted resistors set the pads; a port is disabled only with both lines tied high
	assign strap_pins = {dis_p, dis_m, mode_code, fixed_code, charge_code, smb_pullups};
endmodule

// ---- tb/hub_strap_config_decode_tb.sv ----
`timescale 1ns/1ps
module hub_strap_config_decode_tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] mode = 3'h0, fixc = 3'h0, chgc = 3'h0, stage;
	logic [5:0] dis_p = 6'h00, dis_m = 6'h00, dp, dm, lg, ss, fm, cm, p, m;
	logic [1:0] pu = 2'h0;
	logic [7:0] pin_i = 8'h00, addr = 8'h00, wdata = 8'h00, rdata, o_, oe, up, dn, d, o;
	logic enum_r = 1'b0, wr_r = 1'b0, rd_r = 1'b0, rd_seen = 1'b0, men, sen;
	logic [3:0] fpe;
	hsc_pkg::hsc_strap_type straps;
	hsc_pkg::hsc_bridge_wr_type bwr_r = '0;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int samples_checked = 0;

	always #2 clock = ~clock;

	hsc_board_model u_board (.mode_code(mode), .fixed_code(fixc), .charge_code(chgc),
		.dis_p(dis_p), .dis_m(dis_m), .smb_pullups(pu), .strap_pins(straps));
	hsc_strap_decode u_dut (.clock(clock), .rst(rst), .strap_pins(straps),
		.general_io_pin_i(pin_i), .enumerated(enum_r), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr_r), .reg_rd(rd_r), .reg_rdata(rdata), .bridge_wr(bwr_r),
		.smbus_master_en(men), .smbus_slave_en(sen), .port_dplus_disable_strap(dp),
		.port_dminus_disable_strap(dm), .legacy_port_disable(lg), .ss_port_disable(ss),
		.fixed_port_mask(fm), .charging_port_mask(cm), .config_stage(stage),
		.general_io_pin_o(o_), .general_io_pin_oe(oe), .general_io_pull_up(up),
		.general_io_pull_dn(dn), .fixed_pull_en(fpe));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Port mask selected by a resistor code, none for invalid codes
	function automatic logic [5:0] exp_mask(input logic [2:0] c);
		return (c == 3'h5) ? 6'h3F : (c > 3'h5) ? 6'h00 : (6'h01 << c) - 6'h01;
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		wr_r <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clock);
		wr_r <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		rd_r <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clock);
		rd_r <= 1'b0;
	endtask

	task automatic bwr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		bwr_r <= {1'b1, a, v};
		@(posedge clock);
		bwr_r.wr <= 1'b0;
	endtask

	// Straps stay stable through the whole reset, then a fixed settle
	task automatic boot(input logic [2:0] mc, fc, cc, input logic [1:0] pl);
		@(posedge clock);
		rst <= 1'b1;
		{mode, fixc, chgc, pu} <= {mc, fc, cc, pl};
		{dis_p, dis_m, pin_i} <= 20'($urandom);
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		settle(8);
	endtask

	// Read data stand one cycle after the read strobe
	always @(posedge clock) begin
		if (rd_seen) check(rdata, exp_q.pop_front());
		rd_seen <= rd_r;
	end

	initial begin
		void'($urandom(32'h0294));
		// Every code on every multi-level strap, pads disturbed after capture
		for (int i = 0; i < 10; i++) begin
			boot(3'(i), 3'(i), 3'(7 - i % 8), (i == 1) ? 2'h3 : 2'(i));
			p = dis_p;
			m = dis_m;
			@(posedge clock);
			{dis_p, dis_m, fixc} <= {~p, ~m, 3'h5};
			settle(6);
			check(men, i % 8 == 0);
			check(sen, i % 8 == 1);
			check(dp, p);
			check(dm, m);
			check(lg, p & m);
			check(ss, p & m);
			check(fm, exp_mask(3'(i)));
			check(cm, exp_mask(3'(7 - i % 8)));
			check(stage, (i == 1) ? 3'h2 : 3'h4);
			check(fpe, 4'hF);
		end
		$display("test strap decode done");
		// External stage: pin setup, read-only and unmapped places, then done
		boot(3'h1, 3'h5, 3'h0, 2'h3);
		wr(8'h10, 8'h0F);
		wr(8'h11, 8'h05);
		wr(8'h12, 8'hF0);
		wr(8'h13, 8'h30);
		wr(8'h02, 8'h00);
		rd(8'h10, 8'h0F);
		rd(8'h02, 8'h3F);
		rd(8'h20, 8'h00);
		rd(8'h00, 8'h12);
		rd(8'h01, {2'h0, dis_p & dis_m});
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h02);
		rd(8'h14, pin_i);
		bwr(8'h10, 8'hFF);
		rd(8'h10, 8'h0F);
		settle(2);
		check(oe, 8'h0F);
		check(o_, 8'h05);
		check(up, 8'h30);
		check(dn, 8'hC0);
		wr(8'hFF, 8'h00);
		settle(3);
		check(stage, 3'h4);
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h0F);
		$display("test slave stage done");
		// Runtime setup over both paths while enumerated
		enum_r <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			{d, o} = 16'($urandom);
			if (k % 2) begin
				wr(8'h10, d);
				wr(8'h11, o);
			end else begin
				bwr(8'h10, d);
				bwr(8'h11, o);
			end
			rd(8'h10, d);
			settle(2);
			check(oe, d);
			check(o_, d & o);
		end
		$display("test runtime pins done");
		conclude();
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		conclude();
	end
endmodule
